// File: bench/timer_compare_pulse_pwm_test.sv
// Bench for the compare timer: reset values, unmapped access, match, clearing, inhibit, force.
// Assumes the byte register map of the design; only capture pin one ever moves.
`timescale 1ns/10ps
`default_nettype none
module timer_compare_pulse_pwm_test;
    typedef struct packed {logic [5:0] a; logic [7:0] v; logic [1:0] r;} row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h1;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, cpu_irq_mask = 1'b0;
    logic bready = 1'b1, rready = 1'b1, first_capture_input = 1'b1;
    logic second_capture_input = 1'b1, ext_clock_pin = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, output_pin_one, output_pin_one_oe;
    logic output_pin_two, output_pin_two_oe, timer_irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, d;
    int n_mismatch = 0, compares = 0, cycles = 0;
    // Reset image of every mapped register except the counter, then one unmapped address
    row_s rows [10] = '{'{6'h00, 8'h00, 2'h0}, '{6'h04, 8'h00, 2'h0}, '{6'h08, 8'h00, 2'h0},
        '{6'h0c, 8'h80, 2'h0}, '{6'h10, 8'h00, 2'h0}, '{6'h14, 8'h80, 2'h0},
        '{6'h18, 8'h00, 2'h0}, '{6'h20, 8'h00, 2'h0}, '{6'h24, 8'h00, 2'h0},
        '{6'h28, 8'h00, 2'h2}};
    timer_compare_pulse_pwm dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .cpu_irq_mask, .first_capture_input, .second_capture_input,
        .ext_clock_pin, .output_pin_one, .output_pin_one_oe, .output_pin_two,
        .output_pin_two_oe, .timer_irq);
    always #10 clk = ~clk;
    task final_report;
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            final_report();
        end
    end
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Handshakes are sampled at the falling edge, where nothing the bench drives is moving
    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        logic ah, wh, bh;
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge clk);
            ah = awready;
            wh = wready;
            bh = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        logic gh, hh;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge clk);
            gh = arready;
            hh = rvalid;
            d = rdata;
            rs = rresp;
            @(posedge clk);
            if (gh) arvalid <= 1'b0;
        end while (!hh);
    endtask : rd
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk({output_pin_one, output_pin_one_oe, output_pin_two, timer_irq}, 4'h0);
        foreach (rows[i]) begin
            rd(rows[i].a);
            chk({rs, d}, {rows[i].r, 24'h0, rows[i].v});
        end
        wr(6'h28, 8'h11);
        chk(rs, 2'h2);
        wstrb <= 4'h0;
        wr(6'h0c, 8'h11);
        wstrb <= 4'h1;
        rd(6'h0c);
        chk(d, 32'h80);
        wr(6'h00, 8'h41);
        wr(6'h04, 8'h80);
        wr(6'h0c, 8'h00);
        wr(6'h10, 8'h40);
        wr(6'h1c, 8'h00);
        rd(6'h08);
        chk({timer_irq, output_pin_one, output_pin_one_oe, d[7:0]}, 11'h100);
        for (int i = 0; i < 300 && output_pin_one !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        chk({timer_irq, output_pin_one}, 2'h3);
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge clk);
        chk(timer_irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        rd(6'h08);
        chk(d & 32'h48, 32'h40);
        rd(6'h10);
        rd(6'h08);
        chk(d & 32'h48, 32'h00);
        wr(6'h00, 8'h08);
        repeat (3) @(posedge clk);
        rd(6'h08);
        chk({output_pin_one, d[7:0]}, 9'h000);
        wr(6'h00, 8'h00);
        // A lone high byte gives compare two the value 0000h but keeps it disarmed
        wr(6'h14, 8'h00);
        wr(6'h1c, 8'h00);
        repeat (40) @(posedge clk);
        rd(6'h08);
        chk(d & 32'h08, 32'h0);
        wr(6'h18, 8'h00);
        wr(6'h1c, 8'h00);
        repeat (40) @(posedge clk);
        rd(6'h08);
        chk({output_pin_two_oe, output_pin_two, d[3]}, 3'h1);
        // Pulse: a falling edge on capture pin one gives level two until compare one (0040h)
        wr(6'h00, 8'h04);
        wr(6'h04, 8'ha0);
        first_capture_input <= 1'b0;
        repeat (6) @(posedge clk);
        rd(6'h20);
        chk({output_pin_one, d[15:0]}, 17'h1fffd);
        repeat (140) @(posedge clk);
        rd(6'h08);
        chk({output_pin_one, d[7:6]}, 3'h2);
        // PWM: compare two (0080h) raises pin one and reloads, compare one (0040h) drops it
        wr(6'h18, 8'h80);
        wr(6'h04, 8'h90);
        for (int i = 0; i < 300 && output_pin_one !== 1'b1; i++) @(posedge clk);
        // At most one tick since the reload, so the counter reads fffch or fffdh
        rd(6'h1c);
        chk(d >> 1, 32'h7ffe);
        repeat (120) @(posedge clk);
        chk(output_pin_one, 1'b1);
        repeat (20) @(posedge clk);
        rd(6'h08);
        chk({output_pin_one, d[6]}, 2'h0);
        final_report();
    end
endmodule : timer_compare_pulse_pwm_test
`default_nettype wire

// File: hdl/timer_compare_pulse_pwm.sv
// Output-compare section of a 16-bit free-running timer with AXI4-Lite registers.
// Assumes pins arrive asynchronously and the CPU interrupt mask is on clk.
// Overview of operation
// - Match sets flag, drives pin, requests interrupt
// - Two 16-bit compare values checked every count
// - Compare values software-only, reset to 8000h
// - Pin latches low from reset until match
// - Interrupt needs enable and clear CPU mask
// - Flag cleared by status read, low access
// - High byte write blocks matches until low
// - Low write after status read clears, re-enables
// - Disabled pin stays port; interrupt still allowed
// - Divide-by-2 matches value, others value plus one
// - Force copies level, sets no flag
// - Force ignored in pulse or PWM mode
// - Pulse trigger loads FFFCh, pin, flag, FFFDh
// - Pulse ends on compare value one match
// - Pulse mode: no flag one, pin two idle
// - Pulse trigger sets capture flag one, interrupt
// - Both selects set means PWM only
// - Pulse mode: capture one off, two normal
// - PWM: value two sets level two, one level one
// - PWM: value two match reloads counter FFFCh
// - PWM owns channel one and value two
// - Equal levels hold pin one constant
// - One count resolution, clock divided 2/4/8
// - Both clock selects set picks external clock
// - Force acts only with pin enabled
`timescale 1ns/10ps
`default_nettype none
`include "timer_compare_params.svh"
module timer_compare_pulse_pwm (
    input wire logic clk, // 50 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [`TC_ADDR_W-1:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write byte strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [`TC_ADDR_W-1:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic cpu_irq_mask, // CPU global interrupt mask, 1 blocks
    input wire logic first_capture_input, // First capture pin
    input wire logic second_capture_input, // Second capture pin
    input wire logic ext_clock_pin, // External counter clock pin
    output logic output_pin_one, // Compare pin one level
    output logic output_pin_one_oe, // Pin one driven by the timer
    output logic output_pin_two, // Compare pin two level
    output logic output_pin_two_oe, // Pin two driven by the timer
    output logic timer_irq // Interrupt request, active high
);
    logic [7:0] ctrl_one_q, ctrl_two_q;
    logic [15:0] cmp_q [2];
    logic [15:0] cap_q [2];
    logic [15:0] cnt_q;
    logic cnt_fresh_q;
    logic [1:0] inhibit_q, match_flag_q, match_arm_q, cap_flag_q, cap_arm_q;
    logic pin1_q, pin2_q, irq_q;
    logic [1:0] cap_s1_q, cap_s2_q, cap_prev_q, cap_edge;
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q;
    logic [`TC_ADDR_W-1:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_strb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic wr_fire, wr_en, rd_fire, status_read;
    logic [31:0] rd_val;
    logic rd_ok;
    logic tick, div2, pen1, pen2, lvl1, lvl2;
    logic [1:0] match_hit, match_set, low_access, cap_access;
    logic trig_pulse, pwm_reload, cap1_event, cnt_load;
    timer_compare_pkg::mode_e mode;

    function automatic logic [15:0] match_target(input logic [15:0] v, input logic d2);
        match_target = d2 ? v : v + 16'h0001;
    endfunction : match_target

    function automatic logic is_mapped(input logic [`TC_ADDR_W-1:0] a);
        case (a)
            `TC_OFF_CTRL_ONE, `TC_OFF_CTRL_TWO, `TC_OFF_STATUS, `TC_OFF_CMP1_HI,
            `TC_OFF_CMP1_LO, `TC_OFF_CMP2_HI, `TC_OFF_CMP2_LO, `TC_OFF_COUNTER,
            `TC_OFF_CAP1, `TC_OFF_CAP2: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    timer_timebase u_timebase (
        .clk(clk),
        .rst_n(rst_n),
        .clock_select({ctrl_two_q[`TC_B2_CSH], ctrl_two_q[`TC_B2_CSL]}),
        .ext_edge_select(ctrl_two_q[`TC_B2_EXEDGE]),
        .ext_clock_pin(ext_clock_pin),
        .tick(tick)
    );

    assign div2 = ({ctrl_two_q[`TC_B2_CSH], ctrl_two_q[`TC_B2_CSL]} == `TC_CS_DIV2);
    assign pen1 = ctrl_two_q[`TC_B2_PEN1];
    assign pen2 = ctrl_two_q[`TC_B2_PEN2];
    assign lvl1 = ctrl_one_q[`TC_B1_LVL1];
    assign lvl2 = ctrl_one_q[`TC_B1_LVL2];

    always_comb begin
        if (ctrl_two_q[`TC_B2_PWM]) begin
            mode = timer_compare_pkg::MODE_PWM;
        end else if (ctrl_two_q[`TC_B2_SPM]) begin
            mode = timer_compare_pkg::MODE_PULSE;
        end else begin
            mode = timer_compare_pkg::MODE_COMPARE;
        end
    end

    // AXI4-Lite handshakes: address and data may arrive in either order
    assign awready = !aw_held_q && !bvalid_q;
    assign wready = !w_held_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_en = wr_fire && wr_strb_q && is_mapped(wr_addr_q);
    assign rd_fire = arvalid && arready;
    assign status_read = rd_fire && (araddr == `TC_OFF_STATUS);
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rresp = rresp_q;
    assign rdata = rdata_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            wr_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_held_q <= 1'b0;
            wr_data_q <= 8'h00;
            wr_strb_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_held_q <= 1'b1;
            wr_data_q <= wdata[7:0];
            wr_strb_q <= wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `TC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_addr_q) ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        case (araddr)
            `TC_OFF_CTRL_ONE: rd_val[7:0] = ctrl_one_q;
            `TC_OFF_CTRL_TWO: rd_val[7:0] = ctrl_two_q;
            `TC_OFF_STATUS: begin
                rd_val[`TC_BS_CF1] = cap_flag_q[0];
                rd_val[`TC_BS_MF1] = match_flag_q[0];
                rd_val[`TC_BS_CF2] = cap_flag_q[1];
                rd_val[`TC_BS_MF2] = match_flag_q[1];
            end
            `TC_OFF_CMP1_HI: rd_val[7:0] = cmp_q[0][15:8];
            `TC_OFF_CMP1_LO: rd_val[7:0] = cmp_q[0][7:0];
            `TC_OFF_CMP2_HI: rd_val[7:0] = cmp_q[1][15:8];
            `TC_OFF_CMP2_LO: rd_val[7:0] = cmp_q[1][7:0];
            `TC_OFF_COUNTER: rd_val[15:0] = cnt_q;
            `TC_OFF_CAP1: rd_val[15:0] = cap_q[0];
            `TC_OFF_CAP2: rd_val[15:0] = cap_q[1];
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `TC_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_ok ? `TC_RESP_OKAY : `TC_RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_q <= 8'h00;
            ctrl_two_q <= 8'h00;
        end else if (wr_en && wr_addr_q == `TC_OFF_CTRL_ONE) begin
            ctrl_one_q <= wr_data_q;
        end else if (wr_en && wr_addr_q == `TC_OFF_CTRL_TWO) begin
            ctrl_two_q <= wr_data_q;
        end
    end

    // Capture pins: stage one feeds only stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_s1_q <= 2'h0;
            cap_s2_q <= 2'h0;
            cap_prev_q <= 2'h0;
        end else begin
            cap_s1_q <= {second_capture_input, first_capture_input};
            cap_s2_q <= cap_s1_q;
            cap_prev_q <= cap_s2_q;
        end
    end

    assign cap_edge[0] = ctrl_one_q[`TC_B1_EDGE1] ? (cap_s2_q[0] & ~cap_prev_q[0])
                                                   : (~cap_s2_q[0] & cap_prev_q[0]);
    assign cap_edge[1] = ctrl_two_q[`TC_B2_EDGE2] ? (cap_s2_q[1] & ~cap_prev_q[1])
                                                   : (~cap_s2_q[1] & cap_prev_q[1]);

    // A match is judged once per counter value, right after the value changes
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            assign match_hit[gi] = cnt_fresh_q && !inhibit_q[gi]
                && (cnt_q == match_target(cmp_q[gi], div2));
            assign low_access[gi] = (wr_fire && wr_addr_q == (gi == 0 ? `TC_OFF_CMP1_LO
                                                                      : `TC_OFF_CMP2_LO))
                || (rd_fire && araddr == (gi == 0 ? `TC_OFF_CMP1_LO : `TC_OFF_CMP2_LO));
            assign cap_access[gi] = rd_fire
                && araddr == (gi == 0 ? `TC_OFF_CAP1 : `TC_OFF_CAP2);

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_q[gi] <= `TC_CMP_RESET;
                    inhibit_q[gi] <= 1'b0;
                end else if (wr_en && wr_addr_q == (gi == 0 ? `TC_OFF_CMP1_HI
                                                            : `TC_OFF_CMP2_HI)) begin
                    cmp_q[gi][15:8] <= wr_data_q;
                    inhibit_q[gi] <= 1'b1;
                end else if (wr_en && wr_addr_q == (gi == 0 ? `TC_OFF_CMP1_LO
                                                            : `TC_OFF_CMP2_LO)) begin
                    cmp_q[gi][7:0] <= wr_data_q;
                    inhibit_q[gi] <= 1'b0;
                end
            end

            // Set beats clear so a match landing on the clearing access is kept
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    match_flag_q[gi] <= 1'b0;
                    match_arm_q[gi] <= 1'b0;
                end else begin
                    match_flag_q[gi] <= match_set[gi]
                        | (match_flag_q[gi] & ~(low_access[gi] & match_arm_q[gi]));
                    if (status_read) begin
                        match_arm_q[gi] <= match_flag_q[gi];
                    end else if (low_access[gi]) begin
                        match_arm_q[gi] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cap_arm_q[gi] <= 1'b0;
                end else if (status_read) begin
                    cap_arm_q[gi] <= cap_flag_q[gi];
                end else if (cap_access[gi]) begin
                    cap_arm_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign trig_pulse = (mode == timer_compare_pkg::MODE_PULSE) && cap_edge[0];
    assign pwm_reload = (mode == timer_compare_pkg::MODE_PWM) && match_hit[1];
    assign cap1_event = ((mode == timer_compare_pkg::MODE_COMPARE) && cap_edge[0])
        || trig_pulse || pwm_reload;
    assign match_set[0] = match_hit[0] && (mode == timer_compare_pkg::MODE_COMPARE);
    assign match_set[1] = match_hit[1] && (mode != timer_compare_pkg::MODE_PWM);
    assign cnt_load = trig_pulse || pwm_reload
        || (wr_fire && wr_addr_q == `TC_OFF_COUNTER);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `TC_CNT_LOAD;
            cnt_fresh_q <= 1'b0;
        end else if (cnt_load) begin
            cnt_q <= `TC_CNT_LOAD;
            cnt_fresh_q <= 1'b1;
        end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001;
            cnt_fresh_q <= 1'b1;
        end else begin
            cnt_fresh_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q[0] <= 16'h0000;
            cap_q[1] <= 16'h0000;
        end else begin
            if (trig_pulse) begin
                cap_q[0] <= `TC_CAP_PULSE;
            end else if ((mode == timer_compare_pkg::MODE_COMPARE) && cap_edge[0]) begin
                cap_q[0] <= cnt_q;
            end
            if (cap_edge[1]) begin
                cap_q[1] <= cnt_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_flag_q <= 2'h0;
        end else begin
            cap_flag_q[0] <= cap1_event | (cap_flag_q[0] & ~(cap_access[0] & cap_arm_q[0]));
            cap_flag_q[1] <= cap_edge[1] | (cap_flag_q[1] & ~(cap_access[1] & cap_arm_q[1]));
        end
    end

    // Pin latches move only while their pin is enabled; equal levels give a flat pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin1_q <= 1'b0;
        end else if (pen1) begin
            case (mode)
                timer_compare_pkg::MODE_COMPARE: begin
                    if (match_hit[0] || ctrl_one_q[`TC_B1_FORCE1]) begin
                        pin1_q <= lvl1;
                    end
                end
                timer_compare_pkg::MODE_PULSE: begin
                    if (trig_pulse) begin
                        pin1_q <= lvl2;
                    end else if (match_hit[0]) begin
                        pin1_q <= lvl1;
                    end
                end
                timer_compare_pkg::MODE_PWM: begin
                    if (match_hit[1]) begin
                        pin1_q <= lvl2;
                    end else if (match_hit[0]) begin
                        pin1_q <= lvl1;
                    end
                end
                default: pin1_q <= pin1_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin2_q <= 1'b0;
        end else if (pen2 && (mode == timer_compare_pkg::MODE_COMPARE)) begin
            if (match_hit[1] || ctrl_one_q[`TC_B1_FORCE2]) begin
                pin2_q <= lvl2;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= !cpu_irq_mask
                && ((ctrl_one_q[`TC_B1_CMP_IE] && (|match_flag_q))
                    || (ctrl_one_q[`TC_B1_CAP_IE] && (|cap_flag_q)));
        end
    end

    assign output_pin_one = pin1_q;
    assign output_pin_one_oe = pen1;
    assign output_pin_two = pin2_q;
    assign output_pin_two_oe = pen2;
    assign timer_irq = irq_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_flag_on_match;
        match_set[0] |=> match_flag_q[0];
    endproperty
    a_flag_on_match: assert property (p_flag_on_match) else $error("match flag not set");

    property p_pin_on_match;
        match_hit[0] && pen1 && mode == timer_compare_pkg::MODE_COMPARE
            |=> pin1_q == $past(lvl1);
    endproperty
    a_pin_on_match: assert property (p_pin_on_match) else $error("pin one missed level");

    property p_hi_inhibits;
        wr_en && wr_addr_q == `TC_OFF_CMP1_HI |=> inhibit_q[0] && !match_hit[0];
    endproperty
    a_hi_inhibits: assert property (p_hi_inhibits) else $error("high write not inhibiting");

    property p_irq_mask;
        irq_q |-> !$past(cpu_irq_mask);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq despite cpu mask");

    property p_flag_cause;
        $rose(match_flag_q[0]) |-> $past(match_set[0]);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag set without match");

    property p_flag_holds;
        match_flag_q[0] && !match_arm_q[0] |=> match_flag_q[0];
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag lost without sequence");

    property p_pulse_trigger;
        trig_pulse |=> cnt_q == `TC_CNT_LOAD && cap_q[0] == `TC_CAP_PULSE && cap_flag_q[0];
    endproperty
    a_pulse_trigger: assert property (p_pulse_trigger) else $error("pulse start wrong");

    property p_pwm_reload;
        pwm_reload |=> cnt_q == `TC_CNT_LOAD ##1 1'b1;
    endproperty
    a_pwm_reload: assert property (p_pwm_reload) else $error("pwm period reload missing");

    property p_no_flag1_mode;
        mode != timer_compare_pkg::MODE_COMPARE |=> !$rose(match_flag_q[0]);
    endproperty
    a_no_flag1_mode: assert property (p_no_flag1_mode) else $error("flag one in pulse/pwm");

    c_pulse: cover property (trig_pulse ##[1:1000] match_hit[0]);
    c_pwm: cover property (pwm_reload);
    c_clear: cover property ($fell(match_flag_q[0]));
    c_match2: cover property (match_set[1]);
endmodule : timer_compare_pulse_pwm
`default_nettype wire

// File: hdl/timer_timebase.sv
// Counter tick source: CPU clock divided by 2, 4 or 8, or an external clock.
// Assumes the external clock is well under a quarter of clk.
`timescale 1ns/10ps
`default_nettype none
`include "timer_compare_params.svh"
module timer_timebase (
    input wire logic clk, // System clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic [1:0] clock_select, // Divider or external select
    input wire logic ext_edge_select, // 1: rising external edge counts
    input wire logic ext_clock_pin, // External clock pin, asynchronous
    output logic tick // One-cycle count enable
);
    logic [2:0] pre_q;
    logic [2:0] mask;
    logic ext_s1_q, ext_s2_q, ext_prev_q;
    logic ext_edge;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // First stage feeds only the second; edges are taken further down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
        end
    end

    assign ext_edge = ext_edge_select ? (ext_s2_q & ~ext_prev_q) : (~ext_s2_q & ext_prev_q);

    always_comb begin
        case (clock_select)
            `TC_CS_DIV2: mask = 3'h1;
            `TC_CS_DIV4: mask = 3'h3;
            default: mask = 3'h7;
        endcase
    end

    assign tick = (clock_select == `TC_CS_EXT) ? ext_edge : ((pre_q & mask) == mask);
endmodule : timer_timebase
`default_nettype wire

// File: pkg/timer_compare_params.svh
// Constants for the compare/pulse/PWM timer section: offsets, bits, values.
// Assumes byte-wide registers in the low byte of one AXI4-Lite word; counter and captures read 16 bits.
`ifndef TIMER_COMPARE_PARAMS_SVH
`define TIMER_COMPARE_PARAMS_SVH
`define TC_ADDR_W 6
`define TC_OFF_CTRL_ONE 6'h00
`define TC_OFF_CTRL_TWO 6'h04
`define TC_OFF_STATUS 6'h08
`define TC_OFF_CMP1_HI 6'h0c
`define TC_OFF_CMP1_LO 6'h10
`define TC_OFF_CMP2_HI 6'h14
`define TC_OFF_CMP2_LO 6'h18
`define TC_OFF_COUNTER 6'h1c
`define TC_OFF_CAP1 6'h20
`define TC_OFF_CAP2 6'h24
`define TC_B1_CAP_IE 7
`define TC_B1_CMP_IE 6
`define TC_B1_FORCE2 4
`define TC_B1_FORCE1 3
`define TC_B1_LVL2 2
`define TC_B1_EDGE1 1
`define TC_B1_LVL1 0
`define TC_B2_PEN1 7
`define TC_B2_PEN2 6
`define TC_B2_SPM 5
`define TC_B2_PWM 4
`define TC_B2_CSH 3
`define TC_B2_CSL 2
`define TC_B2_EDGE2 1
`define TC_B2_EXEDGE 0
`define TC_BS_CF1 7
`define TC_BS_MF1 6
`define TC_BS_CF2 4
`define TC_BS_MF2 3
`define TC_CMP_RESET 16'h8000
`define TC_CNT_LOAD 16'hfffc
`define TC_CAP_PULSE 16'hfffd
`define TC_CS_DIV2 2'h0
`define TC_CS_DIV4 2'h1
`define TC_CS_DIV8 2'h2
`define TC_CS_EXT 2'h3
`define TC_RESP_OKAY 2'h0
`define TC_RESP_SLVERR 2'h2
`endif

// File: pkg/timer_compare_pkg.sv
// Types shared by the compare/pulse/PWM timer section.
// Assumes nothing beyond a SystemVerilog compiler.
package timer_compare_pkg;
    typedef enum logic [2:0] {
        MODE_COMPARE = 3'b001,
        MODE_PULSE = 3'b010,
        MODE_PWM = 3'b100
    } mode_e;
endpackage : timer_compare_pkg
